/* File: rtl/dli_top.sv */
// lamp indicator for online status and offline self-test result
`timescale 1ns/10ps
module dli_top #(
    parameter int unsigned HALF_CYC = dli_pkg::BLINK_HALF_CYC,
    parameter int unsigned GAP = dli_pkg::GAP_TICKS
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [3:0] id_switch,
    input wire dli_pkg::dli_online_t online,
    input wire dli_pkg::dli_report_t report,
    output logic diag_mode,
    output dli_pkg::dli_lamps_t lamps
);
    initial begin
        if (GAP < 1) begin
            $error("group gap must be at least one tick");
        end
        // an odd gap would open the next group on a dark half and lose a blink
        if (GAP % 2 != 0) begin
            $error("group gap must be an even number of ticks");
        end
        if (GAP > 256) begin
            $error("group gap exceeds the gap counter");
        end
    end

    ////////////////////////////////////////////////////////////////
    logic tick;
    dli_tick_div #(.DIV(HALF_CYC)) u_div (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .tick(tick)
    );

    // three-stage synchroniser for the id switch pins
    logic [3:0] id_s1_q, id_s2_q, id_s3_q;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            id_s1_q <= 4'h0;
            id_s2_q <= 4'h0;
            id_s3_q <= 4'h0;
        end else begin
            id_s1_q <= id_switch;
            id_s2_q <= id_s1_q;
            id_s3_q <= id_s2_q;
        end
    end

    ////////////////////////////////////////////////////////////////
    // power-on sampling: wait until the synchroniser has settled
    logic [1:0] settle_q;
    logic sampled_q;
    logic diag_q;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            settle_q <= 2'h0;
        end else if (settle_q != dli_pkg::SETTLE_LAST) begin
            settle_q <= settle_q + 2'h1;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            sampled_q <= 1'b0;
            diag_q <= 1'b0;
        end else if (!sampled_q && settle_q == dli_pkg::SETTLE_LAST && id_s2_q == id_s3_q) begin
            sampled_q <= 1'b1;
            diag_q <= (id_s3_q == dli_pkg::DIAG_ID);
        end
    end
    assign diag_mode = diag_q;

    ////////////////////////////////////////////////////////////////
    // blink phase and count-group sequencer
    logic phase_q;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            phase_q <= 1'b0;
        end else if (tick) begin
            phase_q <= ~phase_q;
        end
    end

    typedef enum logic [1:0] {
        ST_BLINK = 2'b01,
        ST_GAP = 2'b10
    } dli_seq_t;
    dli_seq_t seq_q;
    logic [2:0] blinks_q;
    logic [7:0] gap_q;
    logic [2:0] target;
    assign target = 3'(report.result);

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            seq_q <= ST_BLINK;
            blinks_q <= 3'h0;
            gap_q <= 8'h0;
        end else if (tick) begin
            unique case (seq_q)
                ST_BLINK: begin
                    // a blink ends on the falling half
                    if (phase_q) begin
                        if (blinks_q + 3'h1 >= target) begin
                            blinks_q <= 3'h0;
                            gap_q <= 8'h0;
                            seq_q <= ST_GAP;
                        end else begin
                            blinks_q <= blinks_q + 3'h1;
                        end
                    end
                end
                ST_GAP: begin
                    if (gap_q >= 8'(GAP - 1)) begin
                        seq_q <= ST_BLINK;
                    end else begin
                        gap_q <= gap_q + 8'h1;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    logic ready_d, jam_d;
    always_comb begin
        ready_d = 1'b0;
        jam_d = 1'b0;
        if (!sampled_q) begin
            ready_d = 1'b0;
        end else if (diag_q) begin
            if (!report.done) begin
                ready_d = phase_q;
            end else if (report.result == dli_pkg::DLI_RES_RAM) begin
                ready_d = phase_q;
                jam_d = ~phase_q;
            end else if (report.result == dli_pkg::DLI_RES_PASS) begin
                // pass shows as steady ready lamp
                ready_d = 1'b1;
            end else begin
                ready_d = (seq_q == ST_BLINK) && !phase_q;
                jam_d = (seq_q == ST_BLINK) && !phase_q;
            end
        end else if (online.offline_req) begin
            ready_d = 1'b1;
            jam_d = 1'b1;
        end else if (online.paper_err) begin
            jam_d = 1'b1;
        end else if (online.cover_open) begin
            jam_d = phase_q;
        end else if (online.post_busy) begin
            ready_d = phase_q;
        end else begin
            ready_d = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            lamps <= '0;
        end else begin
            lamps.ready <= ready_d;
            lamps.jam <= jam_d;
        end
    end
endmodule

/* File: rtl/dli_pkg.sv */
// package of constants and types for the diagnostic lamp indicator
package dli_pkg;
    localparam int unsigned CLK_HZ = 25_000_000;
    // blink half period and pause between count groups, in milliseconds
    localparam int unsigned BLINK_HALF_MS = 250;
    localparam int unsigned GROUP_GAP_MS = 1500;
    localparam int unsigned BLINK_HALF_CYC = CLK_HZ / 1000 * BLINK_HALF_MS;
    localparam int unsigned GAP_TICKS = GROUP_GAP_MS / BLINK_HALF_MS;
    localparam logic [3:0] DIAG_ID = 4'h8;
    // last count of the power-on wait before the id switch is read
    localparam logic [1:0] SETTLE_LAST = 2'h3;

    typedef enum logic [2:0] {
        DLI_RES_PASS = 3'h0,
        DLI_RES_RAM = 3'h1,
        DLI_RES_ROM = 3'h2,
        DLI_RES_DARK = 3'h3,
        DLI_RES_BRIGHT = 3'h4,
        DLI_RES_GRP2 = 3'h5,
        DLI_RES_GRP1 = 3'h6
    } dli_result_t;

    // online condition inputs, all same-domain levels
    typedef struct packed {
        logic post_busy;
        logic paper_err;
        logic cover_open;
        logic offline_req;
    } dli_online_t;

    // offline self-test report
    typedef struct packed {
        logic done;
        dli_result_t result;
    } dli_report_t;

    typedef struct packed {
        logic ready;
        logic jam;
    } dli_lamps_t;
endpackage

/* File: rtl/dli_tick_div.sv */
// divider that makes the blink tick enable
`timescale 1ns/10ps
module dli_tick_div #(
    parameter int unsigned DIV = 2
) (
    input wire logic clk_sys,
    input wire logic rstn,
    output logic tick
);
    localparam int unsigned W = $clog2(DIV) + 1;
    logic [W-1:0] cnt_q;

    initial begin
        if (DIV < 2) begin
            $error("divider must be at least 2");
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= '0;
        end else if (cnt_q == W'(DIV - 1)) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + W'(1);
        end
    end

    assign tick = (cnt_q == W'(DIV - 1));
endmodule

/* File: bench/dli_lamp_monitor.sv */
// port assertions for the lamp indicator
`timescale 1ns/10ps
module dli_lamp_monitor #(
    parameter int unsigned HALF_CYC = 4,
    parameter int unsigned GAP = 2
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [3:0] id_switch,
    input wire dli_pkg::dli_online_t online,
    input wire dli_pkg::dli_report_t report,
    input wire logic diag_mode,
    input wire dli_pkg::dli_lamps_t lamps
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    logic [31:0] run_q;
    logic rdy_q;
    logic [3:0] up_q;
    // cycles the ready lamp held its level while tests run; up_q marks the id sample as past
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            run_q <= '0;
            rdy_q <= 1'b0;
            up_q <= 4'h0;
        end else begin
            rdy_q <= lamps.ready;
            run_q <= (!diag_mode || report.done || lamps.ready != rdy_q) ? '0 : run_q + 32'h1;
            if (up_q != 4'h8) begin
                up_q <= up_q + 4'h1;
            end
        end
    end
    ////////
    normal_on_a: assert property (!diag_mode && $past(online) == 4'h0 && up_q == 4'h8 |-> lamps == 2'h2)
        else $error("normal lamps");
    paper_err_a: assert property (!diag_mode && $past(online) == 4'h4 && up_q == 4'h8 |-> lamps == 2'h1)
        else $error("paper lamps");
    cover_dark_a: assert property (!diag_mode && $past(online) == 4'h2 |-> !lamps.ready)
        else $error("cover lamps");
    req_both_a: assert property (!diag_mode && $past(online.offline_req) && up_q == 4'h8 |-> lamps == 2'h3)
        else $error("request lamps");
    diag_hold_a: assert property (diag_mode |=> diag_mode)
        else $error("diag dropped");
    diag_entry_a: assert property ($rose(diag_mode) |-> id_switch == dli_pkg::DIAG_ID)
        else $error("diag entry");
    run_blink_a: assert property (diag_mode && !report.done |-> run_q <= HALF_CYC + 1 && !lamps.jam)
        else $error("test blink");
    ram_alt_a: assert property (diag_mode && $past(report) == 4'h9 |-> lamps.ready != lamps.jam)
        else $error("ram blink");
    count_joint_a: assert property (diag_mode && $past(report.done) && $past(report.result) > 3'h1
        |-> lamps.ready == lamps.jam)
        else $error("count blink");
    cover property (diag_mode && report == 4'h9 && lamps.jam);
    cover property (!diag_mode && $rose(lamps.jam));
    cover property (diag_mode && report == 4'hE && $rose(lamps.ready));
endmodule

bind dli_top dli_lamp_monitor #(.HALF_CYC(HALF_CYC), .GAP(GAP)) mon (.clk_sys(clk_sys), .rstn(rstn),
    .id_switch(id_switch), .online(online), .report(report), .diag_mode(diag_mode), .lamps(lamps));

/* File: bench/tb_top.sv */
// bench for the lamp indicator
`timescale 1ns/10ps
module tb_top;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] id_switch = 4'h0;
    dli_pkg::dli_online_t online = '0;
    dli_pkg::dli_report_t report = '0;
    logic diag_mode;
    dli_pkg::dli_lamps_t lamps;
    int fail_count = 0;
    int checks_done = 0;
    dli_top #(.HALF_CYC(4), .GAP(2)) dut (.clk_sys(clk_sys), .rstn(rstn), .id_switch(id_switch),
        .online(online), .report(report), .diag_mode(diag_mode), .lamps(lamps));
    always #20 clk_sys = ~clk_sys;
    ////////
    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic boot(input logic [3:0] id);
        rstn <= 1'b0;
        id_switch <= id;
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (12) @(posedge clk_sys);
    endtask
    // seen levels: ready on, ready off, jam on, jam off
    task automatic watch(output logic [3:0] m);
        m = 4'h0;
        repeat (2) @(posedge clk_sys);
        repeat (24) begin
            @(negedge clk_sys);
            m |= {lamps.ready, !lamps.ready, lamps.jam, !lamps.jam};
        end
    endtask
    // skip two group gaps, then count ready pulses up to the next gap
    task automatic count(output int n);
        int dark;
        int st;
        dark = 0;
        st = 0;
        n = 0;
        repeat (400) begin
            @(negedge clk_sys);
            if (lamps.ready !== 1'b1) begin
                dark++;
            end else begin
                if (dark >= 8) st++;
                if (st == 2 && dark > 0) n++;
                dark = 0;
            end
        end
    endtask
    ////////
    task automatic t_online;
        logic [3:0] m;
        logic [31:0] cnd;
        logic [31:0] exp;
        cnd = 32'h0428_1F6A;
        exp = 32'h967D_AA67;
        boot(4'h3);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_sys);
            online <= cnd[31-4*i -: 4];
            watch(m);
            chk(m, exp[31-4*i -: 4]);
        end
        @(posedge clk_sys);
        id_switch <= dli_pkg::DIAG_ID;
        watch(m);
        chk({3'h0, diag_mode}, 4'h0);
    endtask
    task automatic t_diag;
        logic [3:0] m;
        int n;
        @(posedge clk_sys);
        online <= 4'h1;
        boot(dli_pkg::DIAG_ID);
        chk({3'h0, diag_mode}, 4'h1);
        watch(m);
        chk(m, 4'hD);
        @(posedge clk_sys);
        report <= 4'h8;
        watch(m);
        chk(m, 4'h9);
        @(posedge clk_sys);
        report <= 4'h9;
        watch(m);
        chk(m, 4'hF);
        for (int r = 2; r < 7; r++) begin
            @(posedge clk_sys);
            report <= 4'h8 | 4'(r);
            count(n);
            chk(4'(n), 4'(r));
        end
        @(posedge clk_sys);
        boot(4'h3);
        chk({3'h0, diag_mode}, 4'h0);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        t_online;
        t_diag;
        tally_and_finish;
    end
    initial begin
        #(40 * 6000);
        fail_count++;
        tally_and_finish;
    end
endmodule
